// ==== bench/i2c_addr_irq_status_regs_tb.sv ====
// Purpose: Self-checking bench of the register slice
// Assumes: Partner raises the bus events
// Notes: Reads are scored from a queue
`timescale 1ns/1ps
`include "i2c_regs_consts.svh"
module i2c_addr_irq_status_regs_tb;
    import i2c_regs_pkg::*;
    logic clk = 0, srst = 1, regWrite = 0, regRead = 0, wide = 0, go = 0;
    logic txe = 0, ovr = 0, irq;
    logic [15:0] regAddress = 16'h0000;
    logic [3:0] sel = 4'h0;
    logic [10:0] ev;
    reg_word_type wd = 16'h0000, rdData, rnd, e, q[$];
    target_addr_type inAddr = 10'h000;
    int n_mismatch = 0, n_tests = 0, bp[8] = '{4, 3, 2, 1, 0, 13, 12, 14};
    i2c_addr_irq_status_regs u_dut (.clk, .srst, .regAddress, .regWrite,
        .regRead, .regWriteData(wd), .regReadData(rdData),
        .addressWidthSelect(wide), .addressValid(ev[10]),
        .incomingAddress(inAddr), .startSeen(ev[8]), .stopSeen(ev[9]),
        .txLoaded(ev[0]), .rxLoaded(ev[1]), .accessDone(ev[2]),
        .nackSeen(ev[3]), .arbLostSeen(ev[4]), .nackSentSeen(ev[5]),
        .busBusySet(ev[6]), .targetTransmitSet(ev[7]),
        .receiveOverrun(ovr), .transmitShiftEmpty(txe), .irqRequest(irq));
    i2c_bus_partner u_partner (.clk, .go, .sel, .ev);
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (regRead) chk(rdData, q.pop_front());
    task automatic chk(reg_word_type s, reg_word_type x);
        n_tests++;
        if (s !== x) n_mismatch++;
        if (s !== x) $display("CHECK FAILED t=%0t seen=%h exp=%h",
            $time, s, x);
    endtask
    task automatic acc(logic w, logic [15:0] a, reg_word_type d);
        @(negedge clk);
        regWrite = w;
        regRead = !w;
        regAddress = a;
        wd = d;
        if (!w) q.push_back(d);
        @(negedge clk);
        regWrite = 0;
        regRead = 0;
    endtask
    task automatic pulse(int s);
        @(negedge clk);
        go = 1;
        sel = 4'(s);
        @(negedge clk);
        go = 0;
        @(negedge clk);
    endtask
    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #200us;
        n_mismatch++;
        results();
    end
    initial begin
        rnd = 16'($urandom(20));
        repeat (6) @(posedge clk);
        @(negedge clk);
        srst = 0;
        acc(0, `IRQ_STATUS_OFFSET, `STATUS_RESET);
        acc(0, `IRQ_MASK_OFFSET, 16'h0000);
        acc(0, 16'h1a02, 16'h0000);
        acc(1, `OWN_ADDR_OFFSET, rnd);
        acc(0, `OWN_ADDR_OFFSET, rnd & 16'h03ff);
        acc(1, `IRQ_MASK_OFFSET, 16'hffff);
        acc(0, `IRQ_MASK_OFFSET, 16'h007f);
        acc(1, `IRQ_STATUS_OFFSET, 16'hffff);
        acc(0, `IRQ_STATUS_OFFSET, 16'h0400);
        foreach (bp[i]) begin
            pulse(i);
            chk(16'(irq), 16'(bp[i] < 6));
            acc(0, `IRQ_STATUS_OFFSET, 16'h0400 | 16'(1 << bp[i]));
            acc(1, `IRQ_STATUS_OFFSET, 16'(1 << bp[i]));
        end
        ovr = 1;
        txe = 1;
        acc(1, `IRQ_STATUS_OFFSET, 16'hffff);
        acc(0, `IRQ_STATUS_OFFSET, 16'h0800);
        pulse(7);
        pulse(8);
        acc(0, `IRQ_STATUS_OFFSET, 16'h0800);
        acc(1, `OWN_ADDR_OFFSET, 16'h0385);
        for (int k = 0; k < 4; k++) begin
            wide = k inside {1, 2};
            inAddr = k == 2 ? 10'h385 : k == 3 ? 10'h000 : 10'h005;
            e = k == 1 ? 16'h0800 : k == 3 ? 16'h0b00 : 16'h0a00;
            pulse(10);
            @(negedge clk);
            chk(16'(irq), 16'(k != 1));
            acc(0, `IRQ_STATUS_OFFSET, e);
            pulse(8);
        end
        results();
    end
endmodule // i2c_addr_irq_status_regs_tb

// ==== bench/i2c_bus_partner.sv ====
// Purpose: Bus engine stand-in raising event pulses
// Assumes: Requests come from the bench
// Notes: Pulse follows request by one clock
`timescale 1ns/1ps
module i2c_bus_partner (
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] sel,
    output logic [10:0] ev
);
    always_ff @(posedge clk) begin
        ev <= go ? 11'h001 << sel : 11'h000;
    end
endmodule // i2c_bus_partner

// ==== bench/i2c_regs_asserts.sv ====
// Purpose: Port checks of the register slice
// Assumes: Bound to the top module
// Notes: Reset disables all checks
`timescale 1ns/1ps
`include "i2c_regs_consts.svh"
module i2c_regs_asserts
    import i2c_regs_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [15:0] regAddress,
    input wire logic regWrite,
    input wire logic regRead,
    input wire reg_word_type regWriteData,
    input wire reg_word_type regReadData,
    input wire logic nackSeen,
    input wire logic txLoaded,
    input wire logic irqRequest
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire rdOwn = regRead && regAddress == `OWN_ADDR_OFFSET;
    wire rdMask = regRead && regAddress == `IRQ_MASK_OFFSET;
    wire rdStat = regRead && regAddress == `IRQ_STATUS_OFFSET;
    a_idle_zero: assert property (!regRead |-> regReadData == 16'h0000)
        else $error("idle read data");
    a_addr_upper: assert property (rdOwn |->
        regReadData[15:10] == 6'h00) else $error("own address upper bits");
    a_mask_upper: assert property (rdMask |->
        regReadData[15:7] == 9'h000) else $error("mask upper bits");
    a_stat_reserved: assert property (rdStat |->
        regReadData[15] == 1'b0 && regReadData[7:6] == 2'b00)
        else $error("status reserved bits");
    a_unmapped_zero: assert property (regRead && !rdOwn && !rdMask &&
        !rdStat |-> regReadData == 16'h0000) else $error("unmapped read");
    a_tx_ready: assert property (txLoaded ##1 !regWrite ##1 rdStat
        |-> regReadData[4]) else $error("transmit ready lost");
    a_w1c_clear: assert property (regWrite && regWriteData[1] &&
        !nackSeen && regAddress == `IRQ_STATUS_OFFSET ##1 !nackSeen ##1
        rdStat |-> !regReadData[1]) else $error("flag not cleared");
    a_irq_masked: assert property (rdMask && regReadData == 16'h0000
        |-> !irqRequest) else $error("request while masked");
endmodule // i2c_regs_asserts
bind i2c_addr_irq_status_regs i2c_regs_asserts u_chk (.clk, .srst,
    .regAddress, .regWrite, .regRead, .regWriteData, .regReadData,
    .nackSeen, .txLoaded, .irqRequest);

// ==== common/i2c_regs_consts.svh ====
// Purpose: Offsets, field positions and reset values of the register slice
// Assumes: 16-bit register words at fixed word addresses
// Notes: Definitions only
`ifndef I2C_REGS_CONSTS_SVH
`define I2C_REGS_CONSTS_SVH

`define OWN_ADDR_OFFSET 16'h1a00
`define IRQ_MASK_OFFSET 16'h1a04
`define IRQ_STATUS_OFFSET 16'h1a08

`define OWN_ADDR_BITS 10
`define SHORT_ADDR_BITS 7
`define MASK_BITS 7

`define ST_ARB_LOST 0
`define ST_NACK 1
`define ST_ACCESS_READY 2
`define ST_RX_READY 3
`define ST_TX_READY 4
`define ST_STOP 5
`define ST_GENCALL 8
`define ST_ADDRESSED 9
`define ST_TX_SHIFT_EMPTY_N 10
`define ST_RX_OVERRUN 11
`define ST_BUS_BUSY 12
`define ST_NACK_SENT 13
`define ST_DIRECTION 14

`define STATUS_RESET 16'h0410
`define STATUS_W1C_MASK 16'h703f
`define STATUS_VALID_MASK 16'h7f3f

`endif

// ==== common/i2c_regs_pkg.sv ====
// Purpose: Types shared by the register slice
// Assumes: Nothing beyond the constants header
// Notes: Holds types only
package i2c_regs_pkg;
    typedef logic [15:0] reg_word_type;
    typedef logic [9:0] target_addr_type;
endpackage

// ==== hw/addr_match.sv ====
// Purpose: Compares an incoming bus address with the own address
// Assumes: Address fields already registered by the caller
// Notes: Combinational
`timescale 1ns/1ps
`include "i2c_regs_consts.svh"
module addr_match
    import i2c_regs_pkg::*;
(
    input wire target_addr_type ownAddress,
    input wire logic addressWidthSelect,
    input wire target_addr_type incomingAddress,
    output logic isMatch,
    output logic isGeneralCall
);
    wire logic shortMatch;
    wire logic longMatch;
    assign shortMatch = incomingAddress[`SHORT_ADDR_BITS-1:0] ==
        ownAddress[`SHORT_ADDR_BITS-1:0];
    assign longMatch = incomingAddress == ownAddress;
    assign isGeneralCall = incomingAddress == 10'h000;
    assign isMatch = addressWidthSelect ? longMatch : shortMatch;
endmodule // addr_match

// ==== hw/i2c_addr_irq_status_regs.sv ====
// Purpose: Own address, interrupt mask and interrupt status registers
// Assumes: Bus engine events are single-cycle pulses on clk
// Notes: 16-bit register port at fixed word addresses
//
// Overview of operation
// - In 7-bit mode only own-address bits 6-0 are compared.
// - In 10-bit mode all ten own-address bits are compared.
// - Own-address field is ten read/write bits in a 16-bit register.
// - Unused upper bits read zero and ignore writes.
// - Mask holds seven read/write enable bits, one per request source.
// - Status bits 14-8 and 5-0 report bus and interrupt state.
// - Writing one clears the W1C status bits; zero leaves them.
// - Overrun, shift-empty, addressed and general-call bits ignore writes.
// - After reset shift-empty and transmit-ready read one, others zero.
// - Addressed flag sets on own-address match or general-call address.
// - Transmit-ready sets when transmit data moves to the shift register.
// - Direction flag clears on START or STOP.
`timescale 1ns/1ps
`include "i2c_regs_consts.svh"
module i2c_addr_irq_status_regs
    import i2c_regs_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [15:0] regAddress,
    input wire logic regWrite,
    input wire logic regRead,
    input wire reg_word_type regWriteData,
    output reg_word_type regReadData,
    input wire logic addressWidthSelect,
    input wire logic addressValid,
    input wire target_addr_type incomingAddress,
    input wire logic startSeen,
    input wire logic stopSeen,
    input wire logic txLoaded,
    input wire logic rxLoaded,
    input wire logic accessDone,
    input wire logic nackSeen,
    input wire logic arbLostSeen,
    input wire logic nackSentSeen,
    input wire logic busBusySet,
    input wire logic targetTransmitSet,
    input wire logic receiveOverrun,
    input wire logic transmitShiftEmpty,
    output logic irqRequest
);
    target_addr_type ownAddressField;
    logic [`MASK_BITS-1:0] irqMask;
    reg_word_type status;
    reg_word_type next_status;
    reg_word_type setPulses;
    logic addrHit;
    logic genCall;
    logic addressedFlag;
    logic genCallFlag;
    logic overrunFlag;
    logic shiftEmptyN;

    // Word decode of one register offset
    function automatic logic isOffset(
        input logic [15:0] address,
        input logic [15:0] offset
    );
        return address == offset;
    endfunction

    // One write-one-to-clear flag; a hardware set beats a clear
    function automatic logic flagNext(
        input logic current,
        input logic setEvent,
        input logic clearEvent
    );
        return setEvent | (current & ~clearEvent);
    endfunction

    // Register decode and bus conditions
    wire logic selOwn = isOffset(regAddress, `OWN_ADDR_OFFSET);
    wire logic selMask = isOffset(regAddress, `IRQ_MASK_OFFSET);
    wire logic selStatus = isOffset(regAddress, `IRQ_STATUS_OFFSET);
    wire logic wrOwn = regWrite && selOwn;
    wire logic wrMask = regWrite && selMask;
    wire logic wrStatus = regWrite && selStatus;
    wire logic rdOwn = regRead && selOwn;
    wire logic rdMask = regRead && selMask;
    wire logic rdStatus = regRead && selStatus;
    wire logic busEdge = startSeen || stopSeen;
    wire logic addressTaken = addressValid && (addrHit || genCall);

    // Own-address compare, 7 or 10 bits
    addr_match matcher (
        .ownAddress(ownAddressField),
        .addressWidthSelect(addressWidthSelect),
        .incomingAddress(incomingAddress),
        .isMatch(addrHit),
        .isGeneralCall(genCall)
    );

    // Hardware set events by status bit position
    always_comb begin
        setPulses = 16'h0000;
        setPulses[`ST_ARB_LOST] = arbLostSeen;
        setPulses[`ST_NACK] = nackSeen;
        setPulses[`ST_ACCESS_READY] = accessDone;
        setPulses[`ST_RX_READY] = rxLoaded;
        setPulses[`ST_TX_READY] = txLoaded;
        setPulses[`ST_STOP] = stopSeen;
        setPulses[`ST_BUS_BUSY] = busBusySet;
        setPulses[`ST_NACK_SENT] = nackSentSeen;
        setPulses[`ST_DIRECTION] = targetTransmitSet;
    end

    // Software clears, plus the bus conditions that end a transfer
    wire reg_word_type writeClears = wrStatus ?
        (regWriteData & `STATUS_W1C_MASK) : 16'h0000;
    wire logic clearDirection = writeClears[`ST_DIRECTION] || busEdge;
    wire logic clearBusBusy = writeClears[`ST_BUS_BUSY] || stopSeen;

    // Next status word flag by flag; reserved bits stay zero
    always_comb begin
        next_status = 16'h0000;
        next_status[`ST_ARB_LOST] = flagNext(status[`ST_ARB_LOST],
            setPulses[`ST_ARB_LOST], writeClears[`ST_ARB_LOST]);
        next_status[`ST_NACK] = flagNext(status[`ST_NACK],
            setPulses[`ST_NACK], writeClears[`ST_NACK]);
        next_status[`ST_ACCESS_READY] = flagNext(status[`ST_ACCESS_READY],
            setPulses[`ST_ACCESS_READY], writeClears[`ST_ACCESS_READY]);
        next_status[`ST_RX_READY] = flagNext(status[`ST_RX_READY],
            setPulses[`ST_RX_READY], writeClears[`ST_RX_READY]);
        next_status[`ST_TX_READY] = flagNext(status[`ST_TX_READY],
            setPulses[`ST_TX_READY], writeClears[`ST_TX_READY]);
        next_status[`ST_STOP] = flagNext(status[`ST_STOP],
            setPulses[`ST_STOP], writeClears[`ST_STOP]);
        next_status[`ST_BUS_BUSY] = flagNext(status[`ST_BUS_BUSY],
            setPulses[`ST_BUS_BUSY], clearBusBusy);
        next_status[`ST_NACK_SENT] = flagNext(status[`ST_NACK_SENT],
            setPulses[`ST_NACK_SENT], writeClears[`ST_NACK_SENT]);
        next_status[`ST_DIRECTION] = flagNext(status[`ST_DIRECTION],
            setPulses[`ST_DIRECTION], clearDirection);
        // Read-only bits follow their own flags, one clock later
        next_status[`ST_ADDRESSED] = addressedFlag;
        next_status[`ST_GENCALL] = genCallFlag;
        next_status[`ST_RX_OVERRUN] = overrunFlag;
        next_status[`ST_TX_SHIFT_EMPTY_N] = shiftEmptyN;
    end

    // Own-address field; upper bits of the written word are dropped
    always_ff @(posedge clk) begin
        if (srst) begin
            ownAddressField <= 10'h000;
        end else if (wrOwn) begin
            ownAddressField <= regWriteData[`OWN_ADDR_BITS-1:0];
        end
    end

    // Enable mask, one bit per request source
    always_ff @(posedge clk) begin
        if (srst) begin
            irqMask <= 7'h00;
        end else if (wrMask) begin
            irqMask <= regWriteData[`MASK_BITS-1:0];
        end
    end

    // Addressed and general-call flags; a START or STOP ends the match
    always_ff @(posedge clk) begin
        if (srst) begin
            addressedFlag <= 1'b0;
            genCallFlag <= 1'b0;
        end else if (addressTaken) begin
            addressedFlag <= 1'b1;
            genCallFlag <= genCall;
        end else if (busEdge) begin
            addressedFlag <= 1'b0;
            genCallFlag <= 1'b0;
        end
    end

    // Read-only mirrors of the engine levels
    always_ff @(posedge clk) begin
        if (srst) begin
            overrunFlag <= 1'b0;
            shiftEmptyN <= 1'b1;
        end else begin
            overrunFlag <= receiveOverrun;
            shiftEmptyN <= ~transmitShiftEmpty;
        end
    end

    // Status register, loaded with its reset pattern
    always_ff @(posedge clk) begin
        if (srst) begin
            status <= `STATUS_RESET;
        end else begin
            status <= next_status & `STATUS_VALID_MASK;
        end
    end

    // Register views with reserved bits forced to zero
    wire reg_word_type ownView = {6'h00, ownAddressField};
    wire reg_word_type maskView = {9'h000, irqMask};
    wire reg_word_type statusView = status & `STATUS_VALID_MASK;

    // Same-cycle read data; unmapped words and idle cycles read zero
    always_comb begin
        regReadData = 16'h0000;
        if (rdOwn) begin
            regReadData = ownView;
        end else if (rdMask) begin
            regReadData = maskView;
        end else if (rdStatus) begin
            regReadData = statusView;
        end
    end

    // Mask bit 6 gates the addressed flag, bits 5-0 gate flags 5-0
    wire logic [`MASK_BITS-1:0] irqSources = {status[`ST_ADDRESSED],
        status[`ST_STOP:`ST_ARB_LOST]};
    assign irqRequest = |(irqSources & irqMask);
endmodule // i2c_addr_irq_status_regs
